/* File: wsc_channel.sv */
// One wheel-sensor channel: input synchroniser, deglitch filter and output select.
// Assumes the frame decoder runs on mclk and the sensor comparator level is asynchronous.
`timescale 1ns/100ps
`default_nettype none
module wsc_channel #(
	parameter int CNT_W = 13,
	parameter logic [9:0] FIELD_RST = 10'h000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Configuration
	input wire logic [9:0] chanField,
	input wire logic [CNT_W-1:0] deglitchCyc,
	input wire logic bypassEff,
	input wire logic muteEff,
	// Sensor and decoder side
	input wire logic sensorRaw,
	input wire logic decodedPulse,
	input wire logic standstill,
	// Outputs
	output logic filteredLevel,
	output logic wheelPulseOut
);

	// ----------------------------------------------------------------
	// Synchroniser and change detect
	// ----------------------------------------------------------------
	logic syncA;
	logic syncB;
	logic [9:0] lastField;
	logic [CNT_W-1:0] cnt;
	wire cfgChange = chanField != lastField;
	wire [CNT_W-1:0] cntInc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
	wire settled = cntInc >= deglitchCyc;
	wire next_pulse = bypassEff ? filteredLevel : ((muteEff & standstill) ? 1'b0 : decodedPulse);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			lastField <= FIELD_RST;
		end else begin
			syncA <= sensorRaw;
			syncB <= syncA;
			lastField <= chanField;
		end
	end

	// ----------------------------------------------------------------
	// Deglitch filter
	// ----------------------------------------------------------------
	// A new field restarts only this channel's filter count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			filteredLevel <= 1'b0;
		end else if (cfgChange) begin
			cnt <= '0;
		end else if (syncB == filteredLevel) begin
			cnt <= '0;
		end else if (settled) begin
			cnt <= '0;
			filteredLevel <= syncB;
		end else begin
			cnt <= cntInc;
		end
	end

	// ----------------------------------------------------------------
	// Output select
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wheelPulseOut <= 1'b0;
		end else begin
			wheelPulseOut <= next_pulse;
		end
	end

endmodule : wsc_channel
`default_nettype wire

/* File: wsc_checker.sv */
// Port checker for the wheel-speed channel configuration top.
// Assumes one mclk domain and the asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module wsc_checker (
	// Clock, reset and register access
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [6:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [19:0] regWrData,
	input wire logic [19:0] regRdData,
	input wire logic regWrRefused,
	input wire logic configUnlock,
	// Channel side
	input wire logic [3:0] decodedPulse,
	input wire logic [3:0] standstill,
	input wire logic [3:0] wheelPulseOut,
	input wire logic [3:0] filteredLevel,
	input wire logic [3:0] fixedTripSel,
	input wire logic [3:0] rawPulseBypassEn,
	input wire logic [3:0] haltOutputMute,
	input wire logic [7:0] sensorKindSel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire cfgHit = regWrEn && (regAddr == 7'h0C || regAddr == 7'h0D);
	wire locked = cfgHit && !configUnlock;
	logic [19:0] lastData;
	always_ff @(posedge mclk) lastData <= regWrData;
	chk_refuse_flag: assert property (locked |=> regWrRefused)
		else $error("locked write not flagged");
	chk_refuse_cause: assert property (regWrRefused |-> $past(locked))
		else $error("spurious refusal");
	chk_locked_hold: assert property (locked |=> $stable(sensorKindSel) && $stable(fixedTripSel))
		else $error("locked write changed config");
	chk_low_fields: assert property (cfgHit && configUnlock && !regAddr[0] |=>
		sensorKindSel[3:0] == {lastData[11:10], lastData[1:0]} && fixedTripSel[1:0] == {lastData[13], lastData[3]})
		else $error("ch0/1 fields wrong");
	chk_high_modes: assert property (cfgHit && configUnlock && regAddr[0] |=>
		rawPulseBypassEn[3:2] == {lastData[15], lastData[5]} && haltOutputMute[3:2] == {lastData[14], lastData[4]})
		else $error("ch2/3 mode bits wrong");
	chk_read_hold: assert property (!regRdEn |=> $stable(regRdData))
		else $error("read data moved");
	chk_unmapped_zero: assert property (regRdEn && regAddr[6:1] != 6'h06 |=> regRdData == 20'h00000)
		else $error("unmapped read not zero");
	chk_bypass_out: assert property (rawPulseBypassEn[0] && sensorKindSel[1] |=>
		wheelPulseOut[0] == $past(filteredLevel[0]))
		else $error("pass-through output wrong");
	chk_mute_out: assert property (haltOutputMute[2] && sensorKindSel[5:4] == 2'h2 && !rawPulseBypassEn[2]
		&& standstill[2] |=> !wheelPulseOut[2])
		else $error("standstill not muted");
	chk_decoded_out: assert property (!sensorKindSel[1] |=> wheelPulseOut[0] == $past(decodedPulse[0]))
		else $error("decoded output wrong");
	cov_refused: cover property (regWrRefused);
	cov_bypass: cover property (rawPulseBypassEn[0] && sensorKindSel[1]);
	cov_mute: cover property (haltOutputMute[2] && standstill[2]);
endmodule : wsc_checker
bind wsc_wheel_speed_channel_config wsc_checker chk_u (
	.mclk(mclk),
	.rst_n(rst_n),
	.regAddr(regAddr),
	.regWrEn(regWrEn),
	.regRdEn(regRdEn),
	.regWrData(regWrData),
	.regRdData(regRdData),
	.regWrRefused(regWrRefused),
	.configUnlock(configUnlock),
	.decodedPulse(decodedPulse),
	.standstill(standstill),
	.wheelPulseOut(wheelPulseOut),
	.filteredLevel(filteredLevel),
	.fixedTripSel(fixedTripSel),
	.rawPulseBypassEn(rawPulseBypassEn),
	.haltOutputMute(haltOutputMute),
	.sensorKindSel(sensorKindSel)
);
`default_nettype wire

/* File: wsc_pkg.sv */
// Constants for the wheel-speed channel configuration block.
// Assumes a 100 MHz mclk and the register offsets of the serial register map.
`default_nettype none
package wsc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int REG_W = 20;
	localparam logic [ADDR_W-1:0] ADDR_CFG01 = 7'h0C;
	localparam logic [ADDR_W-1:0] ADDR_CFG23 = 7'h0D;
	localparam logic [REG_W-1:0] CFG01_RST = 20'h20080;
	localparam logic [REG_W-1:0] CFG23_RST = 20'h00000;

	// ----------------------------------------------------------------
	// Channel field layout
	// ----------------------------------------------------------------
	localparam int NUM_CHAN = 4;
	localparam int FLD_W = 10;
	localparam int KIND_LSB = 0;
	localparam int KIND_W = 2;
	localparam int RANGE_BIT = 2;
	localparam int FIXED_BIT = 3;
	localparam int MUTE_BIT = 4;
	localparam int BYPASS_BIT = 5;
	localparam int TIME_LSB = 6;
	localparam int TIME_W = 4;
	localparam logic [FLD_W-1:0] FIELD_RST_LO = 10'h080;
	localparam logic [FLD_W-1:0] FIELD_RST_HI = 10'h000;

	// Sensor kind codes
	localparam logic [KIND_W-1:0] KIND_STD2 = 2'h0;
	localparam logic [KIND_W-1:0] KIND_VDA3 = 2'h1;
	localparam logic [KIND_W-1:0] KIND_PWM_2EDGE = 2'h2;
	localparam logic [KIND_W-1:0] KIND_PWM_1EDGE = 2'h3;

	// ----------------------------------------------------------------
	// Deglitch timing
	// ----------------------------------------------------------------
	localparam int MCLK_NS = 10;
	localparam int DG_BASE_NS = 8000;
	localparam int DG_STEP_NS = 500;
	localparam int DG_R1_NS = 15000;
	localparam int DG_R2_NS = 30000;
	localparam int DG_R3_NS = 50000;
	localparam int DG_BASE_CYC = (DG_BASE_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int DG_STEP_CYC = (DG_STEP_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int DG_R1_CYC = (DG_R1_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int DG_R2_CYC = (DG_R2_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int DG_R3_CYC = (DG_R3_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int CNT_W = 13;

endpackage : wsc_pkg
`default_nettype wire

/* File: wsc_sensor_model.sv */
// Stand-in for the wheel sensors and the frame decoder of all four channels.
// Assumes the bench commands levels and standstill flags at the falling mclk edge.
`timescale 1ns/100ps
`default_nettype none
module wsc_sensor_model (
	// Clock and commands
	input wire logic mclk,
	input wire logic [3:0] rawLevel,
	input wire logic [3:0] stillCmd,
	// Pins towards the block
	output logic [3:0] sensorRaw,
	output logic [3:0] decodedPulse,
	output logic [3:0] standstill
);
	// Comparator levels arrive unrelated to the clock
	assign #3 sensorRaw = rawLevel;
	// Decoder pulses are redrawn at random every cycle so a stale select shows up
	always @(negedge mclk) begin
		decodedPulse <= 4'($urandom);
		standstill <= stillCmd;
	end
endmodule : wsc_sensor_model
`default_nettype wire

/* File: wsc_wheel_speed_channel_config.sv */
// Top of the wheel-speed channel configuration block: two config registers, four channels.
// Assumes a serial-bus decoder presenting register accesses on mclk, and an unlock level
// from the remote sensor control register.
`timescale 1ns/100ps
`default_nettype none
module wsc_wheel_speed_channel_config #(
	parameter int CNT_W = wsc_pkg::CNT_W,
	parameter int DG_BASE_CYC = wsc_pkg::DG_BASE_CYC,
	parameter int DG_STEP_CYC = wsc_pkg::DG_STEP_CYC,
	parameter int DG_R1_CYC = wsc_pkg::DG_R1_CYC,
	parameter int DG_R2_CYC = wsc_pkg::DG_R2_CYC,
	parameter int DG_R3_CYC = wsc_pkg::DG_R3_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register access from the serial bus decoder
	input wire logic [wsc_pkg::ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [wsc_pkg::REG_W-1:0] regWrData,
	output logic [wsc_pkg::REG_W-1:0] regRdData,
	output logic regWrRefused,
	// Unlock level from the control register
	input wire logic configUnlock,
	// Sensor comparator levels and decoder results
	input wire logic [wsc_pkg::NUM_CHAN-1:0] sensorRaw,
	input wire logic [wsc_pkg::NUM_CHAN-1:0] decodedPulse,
	input wire logic [wsc_pkg::NUM_CHAN-1:0] standstill,
	// Per-channel outputs
	output logic [wsc_pkg::NUM_CHAN-1:0] wheelPulseOut,
	output logic [wsc_pkg::NUM_CHAN-1:0] filteredLevel,
	// Configuration to the decoder and threshold logic
	output logic [wsc_pkg::NUM_CHAN-1:0] fixedTripSel,
	output logic [wsc_pkg::NUM_CHAN-1:0] rawPulseBypassEn,
	output logic [wsc_pkg::NUM_CHAN-1:0] haltOutputMute,
	output logic [wsc_pkg::NUM_CHAN*wsc_pkg::KIND_W-1:0] sensorKindSel
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (CNT_W < 2 || CNT_W > 30) begin : gBadWidth
		$error("Deglitch counter width out of range");
	end
	if (DG_BASE_CYC < 1) begin : gBadBase
		$error("Base deglitch count must be positive");
	end
	if (DG_STEP_CYC < 0) begin : gBadStep
		$error("Deglitch step count must not be negative");
	end
	if (DG_R1_CYC < 1 || DG_R2_CYC < 1 || DG_R3_CYC < 1) begin : gBadLong
		$error("Long-range deglitch counts must be positive");
	end
	if (DG_BASE_CYC + ((1 << wsc_pkg::TIME_W) - 1) * DG_STEP_CYC >= (1 << CNT_W)) begin : gBadShortFit
		$error("Short-range deglitch counts do not fit the counter width");
	end
	if (DG_R1_CYC >= (1 << CNT_W) || DG_R2_CYC >= (1 << CNT_W) || DG_R3_CYC >= (1 << CNT_W)) begin : gBadLongFit
		$error("Long-range deglitch counts do not fit the counter width");
	end
	if (wsc_pkg::NUM_CHAN * wsc_pkg::FLD_W != 2 * wsc_pkg::REG_W) begin : gBadMap
		$error("The two config registers must hold every channel field");
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [wsc_pkg::REG_W-1:0] cfg01;
	logic [wsc_pkg::REG_W-1:0] cfg23;

	wire hitCfg01 = regAddr == wsc_pkg::ADDR_CFG01;
	wire hitCfg23 = regAddr == wsc_pkg::ADDR_CFG23;
	wire hitCfg = hitCfg01 | hitCfg23;
	wire wrCfg01 = regWrEn & configUnlock & hitCfg01;
	wire wrCfg23 = regWrEn & configUnlock & hitCfg23;
	wire wrLocked = regWrEn & ~configUnlock & hitCfg;
	wire [wsc_pkg::REG_W-1:0] rdMux = hitCfg01 ? cfg01 : (hitCfg23 ? cfg23 : '0);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg01 <= wsc_pkg::CFG01_RST;
		end else if (wrCfg01) begin
			cfg01 <= regWrData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg23 <= wsc_pkg::CFG23_RST;
		end else if (wrCfg23) begin
			cfg23 <= regWrData;
		end
	end

	// ----------------------------------------------------------------
	// Read data and refused-write flag
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= '0;
			regWrRefused <= 1'b0;
		end else begin
			if (regRdEn) begin
				regRdData <= rdMux;
			end
			regWrRefused <= wrLocked;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel decode and channel instances
	// ----------------------------------------------------------------
	wire [wsc_pkg::NUM_CHAN*wsc_pkg::FLD_W-1:0] allFields = {cfg23, cfg01};

	for (genvar i = 0; i < wsc_pkg::NUM_CHAN; i++) begin : gChan
		localparam logic [wsc_pkg::FLD_W-1:0] FRST = (i < 2) ? wsc_pkg::FIELD_RST_LO : wsc_pkg::FIELD_RST_HI;
		wire [wsc_pkg::FLD_W-1:0] field = allFields[i*wsc_pkg::FLD_W +: wsc_pkg::FLD_W];
		wire [wsc_pkg::TIME_W-1:0] timeSel = field[wsc_pkg::TIME_LSB +: wsc_pkg::TIME_W];
		wire rangeSel = field[wsc_pkg::RANGE_BIT];
		wire [wsc_pkg::KIND_W-1:0] kind = field[wsc_pkg::KIND_LSB +: wsc_pkg::KIND_W];
		wire isPwm = kind == wsc_pkg::KIND_PWM_2EDGE || kind == wsc_pkg::KIND_PWM_1EDGE;
		wire bypassEff = field[wsc_pkg::BYPASS_BIT] & isPwm;
		wire muteEff = field[wsc_pkg::MUTE_BIT] & ~bypassEff & (kind == wsc_pkg::KIND_PWM_2EDGE);
		wire [CNT_W-1:0] stepCyc = CNT_W'(DG_STEP_CYC * int'(timeSel));
		wire [CNT_W-1:0] shortCyc = CNT_W'(DG_BASE_CYC) + stepCyc;
		// Long range reads only the two low filter bits
		wire [1:0] longSel = timeSel[1:0];
		wire [CNT_W-1:0] longCyc = (longSel == 2'h0) ? CNT_W'(DG_BASE_CYC) :
			(longSel == 2'h1) ? CNT_W'(DG_R1_CYC) :
			(longSel == 2'h2) ? CNT_W'(DG_R2_CYC) : CNT_W'(DG_R3_CYC);
		wire [CNT_W-1:0] deglitchCyc = rangeSel ? longCyc : shortCyc;

		assign fixedTripSel[i] = field[wsc_pkg::FIXED_BIT];
		assign rawPulseBypassEn[i] = field[wsc_pkg::BYPASS_BIT];
		assign haltOutputMute[i] = field[wsc_pkg::MUTE_BIT];
		assign sensorKindSel[i*wsc_pkg::KIND_W +: wsc_pkg::KIND_W] = kind;

		wsc_channel #(
			.CNT_W(CNT_W),
			.FIELD_RST(FRST)
		) uChan (
			.mclk(mclk),
			.rst_n(rst_n),
			.chanField(field),
			.deglitchCyc(deglitchCyc),
			.bypassEff(bypassEff),
			.muteEff(muteEff),
			.sensorRaw(sensorRaw[i]),
			.decodedPulse(decodedPulse[i]),
			.standstill(standstill[i]),
			.filteredLevel(filteredLevel[i]),
			.wheelPulseOut(wheelPulseOut[i])
		);
	end

endmodule : wsc_wheel_speed_channel_config
`default_nettype wire

/* File: wsc_wheel_speed_channel_config_test.sv */
// Self-checking bench for the wheel-speed channel configuration block.
// Assumes the sensor model, the bound checker and shortened deglitch counts.
`timescale 1ns/100ps
`default_nettype none
module wsc_wheel_speed_channel_config_test;
	logic mclk = 0, rst_n = 0, wrEn = 0, rdEn = 0, unlock = 0, refused;
	logic [6:0] addr = 0;
	logic [19:0] wData = 0, rData;
	logic [3:0] lvl = 0, still = 0, sRaw, dec, stand, pOut, fLvl, trip, byp, mute;
	logic [7:0] kind;
	int mismatches = 0, samples_checked = 0, cyc = 0, n;
	int shadow [2];
	int cfgTab [6] = '{'h030, 'h3F1, 'h336, 'h377, 'h3BE, 'h3F7};
	int nTab [6] = '{8, 23, 8, 12, 16, 20};
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	wsc_sensor_model mdl_u (.mclk, .rawLevel(lvl), .stillCmd(still), .sensorRaw(sRaw), .decodedPulse(dec),
		.standstill(stand));
	wsc_wheel_speed_channel_config #(.DG_BASE_CYC(8), .DG_STEP_CYC(1), .DG_R1_CYC(12), .DG_R2_CYC(16),
		.DG_R3_CYC(20)) dut_u (.mclk, .rst_n, .regAddr(addr), .regWrEn(wrEn), .regRdEn(rdEn), .regWrData(wData),
		.regRdData(rData), .regWrRefused(refused), .configUnlock(unlock), .sensorRaw(sRaw), .decodedPulse(dec),
		.standstill(stand), .wheelPulseOut(pOut), .filteredLevel(fLvl), .fixedTripSel(trip),
		.rawPulseBypassEn(byp), .haltOutputMute(mute), .sensorKindSel(kind));
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic access(input int a, input logic w, input int d);
		addr = a[6:0];
		wrEn = w;
		rdEn = !w;
		wData = d[19:0];
		@(negedge mclk);
		wrEn = 0;
		rdEn = 0;
		if (w) check(refused, !unlock && a inside {12, 13});
		if (w && unlock && a inside {12, 13}) shadow[a - 12] = d & 'hFFFFF;
		@(negedge mclk);
	endtask : access
	task automatic rd(input int a);
		access(a, 0, 0);
		check(rData, a inside {12, 13} ? shadow[a - 12] : 0);
	endtask : rd
	task automatic cfg_check;
		for (int c = 0; c < 4; c++) begin
			n = shadow[c / 2] >> (10 * (c % 2));
			check({kind[2 * c +: 2], trip[c], mute[c], byp[c]}, {n[1:0], n[3], n[4], n[5]});
		end
	endtask : cfg_check
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(18));
		shadow = '{'h20080, 0};
		repeat (10) @(negedge mclk);
		rst_n = 1;
		rd(12);
		rd(13);
		rd(14);
		cfg_check();
		repeat (4) access(12 + $urandom % 2, 1, $urandom);
		rd(12);
		unlock = 1;
		repeat (8) begin
			still = 4'($urandom);
			access(12 + $urandom % 2, 1, $urandom);
			cfg_check();
		end
		rd(13);
		foreach (cfgTab[i]) begin
			access(12, 1, ($urandom % 1024) << 10 | cfgTab[i]);
			lvl[0] = ~lvl[0];
			repeat (3) @(negedge mclk);
			lvl[0] = ~lvl[0];
			repeat (4) @(negedge mclk);
			check(fLvl[0], lvl[0]);
			lvl[0] = ~lvl[0];
			n = 0;
			while (fLvl[0] !== lvl[0] && n < 60) begin
				@(negedge mclk);
				n++;
			end
			check(n >= nTab[i] + 1 && n <= nTab[i] + 3, 1);
			repeat (2) @(negedge mclk);
			if (cfgTab[i][1]) check(pOut[0], lvl[0]);
			check(fLvl[1], 0);
		end
		still = 4'hF;
		access(13, 1, 'h04812);
		repeat (3) @(negedge mclk);
		check(pOut[3:2], 0);
		rst_n = 0;
		repeat (2) @(negedge mclk);
		rst_n = 1;
		shadow = '{'h20080, 0};
		rd(12);
		rd(13);
		cfg_check();
		end_of_test();
	end
endmodule : wsc_wheel_speed_channel_config_test
`default_nettype wire
